// file: pkg/dit_map.svh
// Register offsets, field positions and timing figures for the DDR2 init controller
`ifndef DIT_MAP_SVH
`define DIT_MAP_SVH
`define DIT_OFF_CTRL      12'h000
`define DIT_OFF_STATUS    12'h004
`define DIT_OFF_MODE      12'h008
`define DIT_OFF_EXTMODE   12'h00C
`define DIT_OFF_TIMING    12'h010
`define DIT_OFF_CMD       12'h014
`define DIT_CTRL_START    0
`define DIT_CTRL_SRATE    1
`define DIT_STS_READY     0
`define DIT_STS_CKE       1
`define DIT_STS_BUSY      2
`define DIT_STS_REJECT    3
`define DIT_CLK_PS        20000
`define DIT_IDLE_NS       200000
`define DIT_CKE_WAIT_NS   400
`define DIT_IDLE_CYC      ((`DIT_IDLE_NS * 1000 + `DIT_CLK_PS - 1) / `DIT_CLK_PS)
`define DIT_CKE_CYC       ((`DIT_CKE_WAIT_NS * 1000 + `DIT_CLK_PS - 1) / `DIT_CLK_PS)
`define DIT_DLL_LOCK_CYC  200
`define DIT_REFRESHES     2
`define DIT_BIT_DLL_RST   8
`define DIT_BIT_ALL_BANKS 10
`define DIT_BIT_DLL_DIS   0
`define DIT_BIT_CAL_LOW   7
`define DIT_BIT_CAL_MID   8
`define DIT_BIT_CAL_HIGH  9
`define DIT_BANK_MODE     3'h0
`define DIT_BANK_EXT      3'h1
`define DIT_BANK_EXT2     3'h2
`define DIT_BANK_EXT3     3'h3
`define DIT_RST_MRD       4'h2
`define DIT_RST_RCD       4'h1
`define DIT_RST_RRD       4'h1
`define DIT_RST_RC        5'h03
`define DIT_RST_FAW       5'h02
`endif

// file: pkg/dit_pkg.sv
// Types for the DDR2 init and activate controller
package dit_pkg;
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  bank;
        logic [13:0] addr;
    } dit_cmd_t;

    typedef struct packed {
        logic [4:0] faw;
        logic [4:0] rc;
        logic [3:0] rrd;
        logic [3:0] rcd;
        logic [3:0] mrd;
    } dit_timing_t;

    typedef enum logic [1:0] {
        DIT_OP_ACT,
        DIT_OP_PRE,
        DIT_OP_RD,
        DIT_OP_WR
    } dit_op_t;
endpackage : dit_pkg

// file: rtl/dit_ctrl.sv
// DDR2 power-up sequencer and activate spacing controller with an APB slave
// What this block does
// - Termination control held low during power-up
// - 200us of NOPs before raising clock enable
// - Clock enable stays high once raised
// - Wait 400ns after clock enable, precharge all
// - Load ext_mode_reg_two with self-refresh rate bit
// - Load ext_mode_reg_three with zeros
// - Load ext_mode_reg enabling DLL, calibration zero
// - Load base_mode_reg with DLL reset bit
// - Clock enable high through 200-cycle DLL lock
// - Precharge all, then two or more refreshes
// - Load base_mode_reg, DLL reset bit low
// - Load ext_mode_reg with calibration bits set
// - Load ext_mode_reg with calibration bits cleared
// - No accesses before 200 cycles after DLL reset
// - All-banks flag for precharge; bank bits select register
// - Activate a bank before reading or writing it
// - Time limits rounded up to whole cycles
// - Same-bank activates need precharge and row cycle time
// - Cross-bank activates spaced by row-to-row delay
// - At most four activates per four-activate window
// - Mode loads wait the mode load delay
`timescale 1ns/100ps
`include "dit_map.svh"
module dit_ctrl
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output dit_pkg::dit_cmd_t        ddr_cmd,
    output logic                     clk_enable,
    output logic                     termination_ctl
);
    import dit_pkg::*;

    localparam int IDLE_CYC = `DIT_IDLE_CYC;
    localparam int CKE_CYC  = `DIT_CKE_CYC;

    typedef enum {
        DIT_S_OFF, DIT_S_IDLE, DIT_S_CKE, DIT_S_PREA1, DIT_S_EXT2, DIT_S_EXT3,
        DIT_S_EXT_DLL, DIT_S_BASE_RST, DIT_S_PREA2, DIT_S_REF, DIT_S_BASE_OP,
        DIT_S_EXT_CAL, DIT_S_EXT_EXIT, DIT_S_LOCK, DIT_S_RUN
    } dit_state_t;

    dit_state_t  state;
    logic [31:0] wait_cnt;
    logic [7:0]  lock_cnt;
    logic [1:0]  ref_cnt;
    logic        start;
    logic        self_refresh_rate;
    logic [13:0] mode_val;
    logic [13:0] ext_val;
    dit_timing_t timing;
    logic        ready;
    logic        reject;
    logic        busy;
    logic        cmd_go;
    dit_op_t     cmd_op;
    logic [2:0]  cmd_bank;
    logic [13:0] cmd_row;
    logic        init_issue;
    dit_cmd_t    init_cmd;

    logic        bank_open [8];
    logic [3:0]  rcd_cnt [8];
    logic [4:0]  rc_cnt  [8];
    logic [3:0]  rrd_cnt;
    logic [4:0]  faw_age [4];
    logic [1:0]  faw_ptr;
    logic        op_ok;
    logic        act_fire;
    logic [3:0]  act_gap;

    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && !penable && !pwrite;

    // APB slave: zero wait states, unmapped offsets flag an error
    assign pready = 1'b1;
    always_comb
    begin
        case (paddr)
            `DIT_OFF_CTRL, `DIT_OFF_STATUS, `DIT_OFF_MODE, `DIT_OFF_EXTMODE,
            `DIT_OFF_TIMING, `DIT_OFF_CMD: pslverr = 1'b0;
            default:                       pslverr = psel && penable;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start             <= 1'b0;
            self_refresh_rate <= 1'b0;
            mode_val          <= 14'h0000;
            ext_val           <= 14'h0000;
            timing            <= {`DIT_RST_FAW, `DIT_RST_RC, `DIT_RST_RRD, `DIT_RST_RCD,
                                  `DIT_RST_MRD};
        end
        else if (wr_en)
        begin
            case (paddr)
                `DIT_OFF_CTRL:
                begin
                    start             <= pwdata[`DIT_CTRL_START];
                    self_refresh_rate <= pwdata[`DIT_CTRL_SRATE];
                end
                `DIT_OFF_MODE:    mode_val <= pwdata[13:0];
                `DIT_OFF_EXTMODE: ext_val  <= pwdata[13:0];
                `DIT_OFF_TIMING:  timing   <= pwdata[21:0];
                default:          ;
            endcase
        end
    end

    // Read data registered during setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (paddr)
                `DIT_OFF_CTRL:    prdata <= {30'h0, self_refresh_rate, start};
                `DIT_OFF_STATUS:  prdata <= {28'h0, reject, busy, clk_enable, ready};
                `DIT_OFF_MODE:    prdata <= {18'h0, mode_val};
                `DIT_OFF_EXTMODE: prdata <= {18'h0, ext_val};
                `DIT_OFF_TIMING:  prdata <= {10'h0, timing};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Command requests from software: op in [1:0], bank in [4:2], row in [18:5]
    assign cmd_go   = wr_en && paddr == `DIT_OFF_CMD;
    assign cmd_op   = dit_op_t'(pwdata[1:0]);
    assign cmd_bank = pwdata[4:2];
    assign cmd_row  = pwdata[18:5];

    // Power-up sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state    <= DIT_S_OFF;
            wait_cnt <= 32'h0000_0000;
            ref_cnt  <= 2'h0;
        end
        else if (wait_cnt != 32'h0000_0000)
            wait_cnt <= wait_cnt - 32'h0000_0001;
        else
        begin
            case (state)
                DIT_S_OFF:
                    if (start)
                    begin
                        state    <= DIT_S_IDLE;
                        wait_cnt <= 32'(IDLE_CYC);
                    end
                DIT_S_IDLE:
                begin
                    state    <= DIT_S_CKE;
                    wait_cnt <= 32'(CKE_CYC);
                end
                DIT_S_CKE:      state <= DIT_S_PREA1;
                DIT_S_PREA1:    state <= DIT_S_EXT2;
                DIT_S_EXT2, DIT_S_EXT3, DIT_S_EXT_DLL, DIT_S_BASE_RST, DIT_S_BASE_OP,
                DIT_S_EXT_CAL:
                begin
                    state    <= dit_state_t'(state + 1);
                    wait_cnt <= 32'(timing.mrd);
                    ref_cnt  <= 2'h0;
                end
                DIT_S_PREA2:    state <= DIT_S_REF;
                DIT_S_REF:
                begin
                    ref_cnt <= ref_cnt + 2'h1;
                    if (ref_cnt == 2'(`DIT_REFRESHES - 1))
                        state <= DIT_S_BASE_OP;
                    else
                        wait_cnt <= 32'(timing.rc);
                end
                DIT_S_EXT_EXIT:
                begin
                    state    <= DIT_S_LOCK;
                    wait_cnt <= 32'(timing.mrd);
                end
                DIT_S_LOCK:     if (lock_cnt == 8'h00) state <= DIT_S_RUN;
                default:        ;
            endcase
        end
    end

    // Lock counter starts at the DLL reset load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lock_cnt <= 8'h00;
        else if (state == DIT_S_BASE_RST && wait_cnt == 32'h0000_0000)
            lock_cnt <= 8'(`DIT_DLL_LOCK_CYC - 1);
        else if (lock_cnt != 8'h00)
            lock_cnt <= lock_cnt - 8'h01;
    end

    assign ready = state == DIT_S_RUN;
    assign busy  = state != DIT_S_OFF && state != DIT_S_RUN;

    // Clock enable rises after the idle period and never falls again
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clk_enable <= 1'b0;
        else if (state == DIT_S_IDLE && wait_cnt == 32'h0000_0000)
            clk_enable <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            termination_ctl <= 1'b0;
        else
            termination_ctl <= 1'b0;
    end

    // Init command selection
    always_comb
    begin
        init_issue = wait_cnt == 32'h0000_0000;
        init_cmd   = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                       bank: 3'h0, addr: 14'h0000};
        case (state)
            DIT_S_PREA1, DIT_S_PREA2:
            begin
                init_cmd.ras_n                     = 1'b0;
                init_cmd.we_n                      = 1'b0;
                init_cmd.addr[`DIT_BIT_ALL_BANKS]  = 1'b1;
            end
            DIT_S_REF:
            begin
                init_cmd.ras_n = 1'b0;
                init_cmd.cas_n = 1'b0;
            end
            DIT_S_EXT2, DIT_S_EXT3, DIT_S_EXT_DLL, DIT_S_BASE_RST, DIT_S_BASE_OP,
            DIT_S_EXT_CAL, DIT_S_EXT_EXIT:
            begin
                init_cmd.ras_n = 1'b0;
                init_cmd.cas_n = 1'b0;
                init_cmd.we_n  = 1'b0;
                case (state)
                    DIT_S_EXT2:
                    begin
                        init_cmd.bank                    = `DIT_BANK_EXT2;
                        init_cmd.addr[`DIT_BIT_CAL_LOW]  = self_refresh_rate;
                    end
                    DIT_S_EXT3:    init_cmd.bank = `DIT_BANK_EXT3;
                    DIT_S_EXT_DLL:
                    begin
                        init_cmd.bank                    = `DIT_BANK_EXT;
                        init_cmd.addr[`DIT_BIT_DLL_DIS]  = 1'b0;
                    end
                    DIT_S_BASE_RST:
                    begin
                        init_cmd.bank                    = `DIT_BANK_MODE;
                        init_cmd.addr[`DIT_BIT_DLL_RST]  = 1'b1;
                    end
                    DIT_S_BASE_OP:
                    begin
                        init_cmd.bank                    = `DIT_BANK_MODE;
                        init_cmd.addr                    = mode_val;
                        init_cmd.addr[`DIT_BIT_DLL_RST]  = 1'b0;
                    end
                    DIT_S_EXT_CAL:
                    begin
                        init_cmd.bank                    = `DIT_BANK_EXT;
                        init_cmd.addr                    = ext_val;
                        init_cmd.addr[`DIT_BIT_DLL_DIS]  = 1'b0;
                        init_cmd.addr[`DIT_BIT_CAL_LOW]  = 1'b1;
                        init_cmd.addr[`DIT_BIT_CAL_MID]  = 1'b1;
                        init_cmd.addr[`DIT_BIT_CAL_HIGH] = 1'b1;
                    end
                    default:
                    begin
                        init_cmd.bank                    = `DIT_BANK_EXT;
                        init_cmd.addr                    = ext_val;
                        init_cmd.addr[`DIT_BIT_DLL_DIS]  = 1'b0;
                        init_cmd.addr[`DIT_BIT_CAL_LOW]  = 1'b0;
                        init_cmd.addr[`DIT_BIT_CAL_MID]  = 1'b0;
                        init_cmd.addr[`DIT_BIT_CAL_HIGH] = 1'b0;
                    end
                endcase
            end
            default: init_issue = 1'b0;
        endcase
    end

    // Spacing checks for software commands
    always_comb
    begin
        op_ok = ready;
        case (cmd_op)
            DIT_OP_ACT:
                op_ok = ready && !bank_open[cmd_bank] && rc_cnt[cmd_bank] == 5'h00
                        && rrd_cnt == 4'h0 && faw_age[faw_ptr] == 5'h00;
            DIT_OP_RD, DIT_OP_WR:
                op_ok = ready && bank_open[cmd_bank] && rcd_cnt[cmd_bank] == 4'h0;
            default: op_ok = ready;
        endcase
    end

    assign act_fire = cmd_go && op_ok && cmd_op == DIT_OP_ACT;

    // Per-bank open flags and timers
    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_bank
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    bank_open[b] <= 1'b0;
                    rcd_cnt[b]   <= 4'h0;
                    rc_cnt[b]    <= 5'h00;
                end
                else if (act_fire && cmd_bank == 3'(b))
                begin
                    bank_open[b] <= 1'b1;
                    rcd_cnt[b]   <= timing.rcd - 4'h1;
                    rc_cnt[b]    <= timing.rc - 5'h01;
                end
                else
                begin
                    if (cmd_go && op_ok && cmd_op == DIT_OP_PRE && cmd_bank == 3'(b))
                        bank_open[b] <= 1'b0;
                    if (rcd_cnt[b] != 4'h0)
                        rcd_cnt[b] <= rcd_cnt[b] - 4'h1;
                    if (rc_cnt[b] != 5'h00)
                        rc_cnt[b] <= rc_cnt[b] - 5'h01;
                end
            end
        end
    endgenerate

    // Four-slot activate history for the rolling window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rrd_cnt <= 4'h0;
            faw_ptr <= 2'h0;
            for (int i = 0; i < 4; i++)
                faw_age[i] <= 5'h00;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                if (faw_age[i] != 5'h00)
                    faw_age[i] <= faw_age[i] - 5'h01;
            if (rrd_cnt != 4'h0)
                rrd_cnt <= rrd_cnt - 4'h1;
            if (act_fire)
            begin
                rrd_cnt          <= timing.rrd - 4'h1;
                faw_age[faw_ptr] <= timing.faw - 5'h01;
                faw_ptr          <= faw_ptr + 2'h1;
            end
        end
    end

    // Cycles since the last activate, saturating, for the spacing check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            act_gap <= 4'hF;
        else if (act_fire)
            act_gap <= 4'h1;
        else if (act_gap != 4'hF)
            act_gap <= act_gap + 4'h1;
    end

    // Command output register and sticky reject flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ddr_cmd <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                         bank: 3'h0, addr: 14'h0000};
        else if (init_issue)
            ddr_cmd <= init_cmd;
        else if (cmd_go && op_ok)
        begin
            ddr_cmd.cs_n  <= 1'b0;
            ddr_cmd.bank  <= cmd_bank;
            ddr_cmd.addr  <= cmd_row;
            ddr_cmd.ras_n <= !(cmd_op == DIT_OP_ACT || cmd_op == DIT_OP_PRE);
            ddr_cmd.cas_n <= !(cmd_op == DIT_OP_RD || cmd_op == DIT_OP_WR);
            ddr_cmd.we_n  <= !(cmd_op == DIT_OP_PRE || cmd_op == DIT_OP_WR);
        end
        else
            ddr_cmd <= '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                         bank: 3'h0, addr: 14'h0000};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reject <= 1'b0;
        else if (cmd_go && !op_ok)
            reject <= 1'b1;
        else if (wr_en && paddr == `DIT_OFF_STATUS && pwdata[`DIT_STS_REJECT])
            reject <= 1'b0;
    end

    a_cke_stays_high: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(clk_enable) |-> 1'b0) else $error("clock enable fell");
    a_termination_low: assert property (@(posedge pclk) disable iff (!presetn)
        !termination_ctl) else $error("termination driven");
    a_no_early_act: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && !ready |=> reject) else $error("early command not refused");
    a_rrd_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        act_fire |-> act_gap >= timing.rrd) else $error("row-to-row spacing broken");
    a_rd_needs_open: assert property (@(posedge pclk) disable iff (!presetn)
        !ddr_cmd.cs_n && ddr_cmd.ras_n && !ddr_cmd.cas_n |-> bank_open[ddr_cmd.bank])
        else $error("access to closed bank");
    a_cke_before_prea: assert property (@(posedge pclk) disable iff (!presetn)
        state == DIT_S_PREA1 |-> clk_enable) else $error("precharge before cke");
    a_dll_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        lock_cnt != 8'h00 |-> clk_enable && state != DIT_S_RUN)
        else $error("run during dll lock");
    a_same_bank_rc: assert property (@(posedge pclk) disable iff (!presetn)
        act_fire |=> rc_cnt[$past(cmd_bank)] == $past(timing.rc) - 5'h01)
        else $error("rc timer not loaded");
    c_ready: cover property (@(posedge pclk) $rose(ready));
    c_act: cover property (@(posedge pclk) act_fire);
    c_reject: cover property (@(posedge pclk) $rose(reject));
endmodule : dit_ctrl

// file: sim/dit_mem_model.sv
// Behavioural DDR2 device: checks power-up order, spacing and bank state
`timescale 1ns/100ps
module dit_mem_model
#(
    parameter int MRD = 2
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire dit_pkg::dit_cmd_t ddr_cmd,
    input  wire logic              clk_enable,
    input  wire logic              termination_ctl,
    input  wire logic              srate,
    input  wire logic [13:0]       mode_val,
    input  wire logic [13:0]       ext_val,
    output logic [15:0]            viol,
    output logic [3:0]             step,
    output logic [15:0]            since_dll
);
    import dit_pkg::*;
    logic [2:0]  rcw;
    logic        cmd_on;
    logic        access;
    logic        full;
    logic        match;
    logic        cke_q;
    logic [2:0]  exp_rcw;
    logic [2:0]  exp_ba;
    logic [13:0] exp_addr;
    logic [7:0]  open;
    logic [7:0]  bad;
    logic [15:0] since_cke;
    logic [15:0] since_lm;
    assign rcw    = {ddr_cmd.ras_n, ddr_cmd.cas_n, ddr_cmd.we_n};
    assign cmd_on = ddr_cmd.cs_n == 1'b0 && rcw != 3'b111;
    assign access = rcw == 3'b011 || rcw[2:1] == 2'b10;
    always_comb
    begin
        full    = !(step == 4'd0 || step == 4'd5 || step == 4'd6 || step == 4'd7);
        exp_rcw = (step == 4'd0 || step == 4'd5) ? 3'b010 : (full ? 3'b000 : 3'b001);
        exp_ba  = (step == 4'd1) ? 3'h2 : (step == 4'd2) ? 3'h3 :
                  (step == 4'd3 || step >= 4'd9) ? 3'h1 : 3'h0;
        case (step)
            4'd1:    exp_addr = {6'h00, srate, 7'h00};
            4'd4:    exp_addr = 14'h0100;
            4'd8:    exp_addr = mode_val;
            4'd9:    exp_addr = ext_val | 14'h0380;
            4'd10:   exp_addr = ext_val & ~14'h0380;
            default: exp_addr = 14'h0000;
        endcase
        match  = rcw == exp_rcw && (full ? ddr_cmd.bank == exp_ba && ddr_cmd.addr == exp_addr
                                         : rcw != 3'b010 || ddr_cmd.addr[10]);
        bad[0] = termination_ctl != 1'b0;
        bad[1] = cmd_on && !clk_enable;
        bad[2] = cke_q && !clk_enable;
        bad[3] = cmd_on && step == 4'd0 && since_cke < 16'd20;
        bad[4] = cmd_on && since_lm < 16'(MRD);
        bad[5] = cmd_on && step < 4'd11 && !match;
        bad[6] = cmd_on && access && (step < 4'd11 || since_dll < 16'd200);
        bad[7] = cmd_on && (rcw == 3'b011 ? open[ddr_cmd.bank]
                                          : rcw[2:1] == 2'b10 && !open[ddr_cmd.bank]);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            viol      <= '0;
            step      <= '0;
            since_dll <= '0;
            since_cke <= '0;
            since_lm  <= 16'h0100;
            cke_q     <= 1'b0;
            open      <= '0;
        end
        else
        begin
            viol      <= viol + 16'($countones(bad));
            cke_q     <= clk_enable;
            since_cke <= clk_enable ? since_cke + 16'd1 : 16'd0;
            since_lm  <= (cmd_on && rcw == 3'b000) ? 16'd1 : since_lm + 16'd1;
            // DLL lock time counted from the reset load
            since_dll <= (cmd_on && step == 4'd4) ? 16'd1 :
                         (since_dll != 16'd0 ? since_dll + 16'd1 : 16'd0);
            if (cmd_on && step < 4'd11)
                step <= step + 4'd1;
            if (cmd_on && rcw == 3'b011)
                open[ddr_cmd.bank] <= 1'b1;
            if (cmd_on && rcw == 3'b010)
                open <= ddr_cmd.addr[10] ? 8'h00 : open & ~(8'h01 << ddr_cmd.bank);
        end
    end
endmodule : dit_mem_model

// file: sim/tb_top.sv
// Self-checking bench for the DDR2 init and activate controller
`timescale 1ns/100ps
`include "dit_map.svh"
module tb_top;
    import dit_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dit_cmd_t    ddr_cmd;
    dit_cmd_t    last_cmd;
    logic        clk_enable;
    logic        termination_ctl;
    logic [15:0] viol;
    logic [3:0]  step;
    logic [15:0] since_dll;
    logic [31:0] rd;
    logic        err;
    int          cmd_cnt;
    int          bad_count;
    int          comparisons;
    int          cycles;
    int          n;

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    dit_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ddr_cmd(ddr_cmd), .clk_enable(clk_enable),
        .termination_ctl(termination_ctl));

    dit_mem_model mem (.pclk(pclk), .presetn(presetn), .ddr_cmd(ddr_cmd),
        .clk_enable(clk_enable), .termination_ctl(termination_ctl), .srate(1'b1),
        .mode_val(14'h0432), .ext_val(14'h0044), .viol(viol), .step(step),
        .since_dll(since_dll));

    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Issues one software command and checks whether it reached the device pins
    task automatic sw_cmd(input dit_op_t op, input logic [2:0] ba, input logic ok);
        logic [11:0] map;
        map = {3'b100, 3'b101, 3'b010, 3'b011};
        n = cmd_cnt;
        apb(1'b1, `DIT_OFF_CMD, {13'h0000, 14'h0055, ba, op});
        repeat (2) @(posedge pclk);
        check(32'(cmd_cnt - n), {31'h0, ok});
        if (ok)
            check({26'h0, last_cmd.ras_n, last_cmd.cas_n, last_cmd.we_n, last_cmd.bank},
                  {26'h0, map[op * 3 +: 3], ba});
    endtask : sw_cmd

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (ddr_cmd.cs_n === 1'b0 && {ddr_cmd.ras_n, ddr_cmd.cas_n, ddr_cmd.we_n} !== 3'b111)
        begin
            last_cmd <= ddr_cmd;
            cmd_cnt  <= cmd_cnt + 1;
        end
        if (cycles == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cmd_cnt = 0;
        cycles = 0;
        bad_count = 0;
        comparisons = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DIT_OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `DIT_OFF_TIMING, 32'h0);
        check(rd, 32'h00043112);
        apb(1'b0, 12'h018, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, `DIT_OFF_MODE, 32'h0432);
        apb(1'b1, `DIT_OFF_EXTMODE, 32'h0044);
        sw_cmd(DIT_OP_ACT, 3'h0, 1'b0);
        apb(1'b0, `DIT_OFF_STATUS, 32'h0);
        check(rd, 32'h8);
        apb(1'b1, `DIT_OFF_STATUS, 32'h8);
        apb(1'b0, `DIT_OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, `DIT_OFF_CTRL, 32'h3);
        n = cycles;
        while (clk_enable !== 1'b1)
            @(posedge pclk);
        check({31'h0, cycles - n >= 10000}, 32'h1);
        apb(1'b0, `DIT_OFF_STATUS, 32'h0);
        check(rd, 32'h6);
        do
            apb(1'b0, `DIT_OFF_STATUS, 32'h0);
        while (rd[0] !== 1'b1);
        check({31'h0, since_dll >= 16'd200 && since_dll <= 16'd210}, 32'h1);
        check(rd, 32'h3);
        check({28'h0, step}, 32'hB);
        // Long spacing: row-to-row, activate-to-access and row cycle all 15 or more
        apb(1'b1, `DIT_OFF_TIMING, {10'h0, 5'd31, 5'd31, 4'd15, 4'd15, 4'd2});
        sw_cmd(DIT_OP_ACT, 3'h0, 1'b1);
        sw_cmd(DIT_OP_ACT, 3'h1, 1'b0);
        sw_cmd(DIT_OP_RD, 3'h0, 1'b0);
        sw_cmd(DIT_OP_RD, 3'h2, 1'b0);
        sw_cmd(DIT_OP_PRE, 3'h0, 1'b1);
        sw_cmd(DIT_OP_ACT, 3'h0, 1'b0);
        repeat (40) @(posedge pclk);
        sw_cmd(DIT_OP_ACT, 3'h0, 1'b1);
        sw_cmd(DIT_OP_ACT, 3'h0, 1'b0);
        // Short spacing, wide window: the fifth activate must wait for the window
        apb(1'b1, `DIT_OFF_TIMING, {10'h0, 5'd31, 5'd3, 4'd4, 4'd1, 4'd2});
        repeat (40) @(posedge pclk);
        for (int b = 3; b < 7; b++)
            sw_cmd(DIT_OP_ACT, 3'(b), 1'b1);
        sw_cmd(DIT_OP_ACT, 3'h7, 1'b0);
        sw_cmd(DIT_OP_RD, 3'h3, 1'b1);
        sw_cmd(DIT_OP_WR, 3'h3, 1'b1);
        repeat (15) @(posedge pclk);
        sw_cmd(DIT_OP_ACT, 3'h7, 1'b1);
        check({16'h0, viol}, 32'h0);
        end_of_test();
    end
endmodule : tb_top
